// *** inc/sblc_pkg.sv ***
// Constants shared by the shared-buffer limit control block.
// Assumes an APB master with 32-bit data and word-aligned registers.
package sblc_pkg;

  // ------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------------
  localparam logic [13:0] IDX_BUFFER_MGR_CONFIG = 14'h1c00;
  localparam logic [13:0] IDX_PER_PORT_DROP_LIMITS = 14'h1c01;
  localparam logic [13:0] IDX_PAUSE_THRESHOLDS = 14'h1c02;
  localparam logic [13:0] IDX_RESUME_THRESHOLDS = 14'h1c03;
  localparam logic [13:0] IDX_FLOOD_TRAFFIC_BUFFER_LIMIT = 14'h1c04;
  localparam logic [13:0] IDX_HOST_PORT_DROP_COUNTER = 14'h1c05;
  localparam int ADDR_W = 16;
  localparam int WORD_LSB = 2;

  // ------------------------------------------------------------------
  // Field layout
  // ------------------------------------------------------------------
  localparam int CFG_W = 7;
  localparam int CFG_CTR_TEST = 6;
  localparam int CFG_FIXED_PRIO = 5;
  localparam int CFG_PACE_HI = 4;
  localparam int CFG_PACE_LO = 2;
  localparam int CFG_YELLOW = 1;
  localparam int CFG_RED = 0;
  localparam int LVL_W = 8;
  localparam int LO_FIELD_LSB = 8;
  localparam int HI_FIELD_LSB = 0;
  localparam int NUM_PORTS = 3;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [CFG_W-1:0] CFG_RST = 7'h00;
  localparam logic [LVL_W-1:0] DROP_LO_RST = 8'h49;
  localparam logic [LVL_W-1:0] DROP_HI_RST = 8'h64;
  localparam logic [LVL_W-1:0] PAUSE_LO_RST = 8'h21;
  localparam logic [LVL_W-1:0] PAUSE_HI_RST = 8'h3c;
  localparam logic [LVL_W-1:0] RESUME_LO_RST = 8'h03;
  localparam logic [LVL_W-1:0] RESUME_HI_RST = 8'h07;
  localparam logic [LVL_W-1:0] FLOOD_RST = 8'h31;
  localparam logic [31:0] DROP_CNT_RST = 32'h0000_0000;

  // ------------------------------------------------------------------
  // Behaviour constants
  // ------------------------------------------------------------------
  localparam int BUFFER_BYTES = 128;
  localparam int ACTIVE_BUFFERS = 36;
  localparam int LOW_SET_PORTS = 2;
  localparam logic [31:0] CTR_TEST_VALUE = 32'h7fff_fffc;
  localparam logic [31:0] CTR_MAX = 32'hffff_ffff;
  localparam logic [15:0] RESUME_PAUSE_TIME = 16'h0001;
  localparam logic [15:0] PAUSE_TIME_RST = 16'h0000;

endpackage

// *** hw/sblc_top.sv ***
// Register bank and threshold logic of the shared packet buffer manager.
// Assumes an APB master on sys_clk_in and buffer usage counts that are
// synchronous to the same clock; drop pulses are one cycle per packet.
`timescale 1ns/1ps

module sblc_top
  import sblc_pkg::*;
#(
  parameter int BUF_CNT_W = 9,
  parameter logic [15:0] PAUSE_TIME = 16'hffff
)
(
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [sblc_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic pready_out,
  output logic [31:0] prdata_out,
  output logic pslverr_out,
  input wire logic [sblc_pkg::NUM_PORTS-1:0][BUF_CNT_W-1:0] port_used_in,
  input wire logic [BUF_CNT_W-1:0] flood_used_in,
  input wire logic [sblc_pkg::NUM_PORTS-1:0] pkt_yellow_in,
  input wire logic [sblc_pkg::NUM_PORTS-1:0] pkt_red_in,
  input wire logic port0_drop_in,
  output logic fixed_prio_out,
  output logic [sblc_pkg::NUM_PORTS-1:0] egress_pace_en_out,
  output logic [sblc_pkg::NUM_PORTS-1:0] yellow_discard_out,
  output logic [sblc_pkg::NUM_PORTS-1:0] red_drop_out,
  output logic [1:0] active_ports_out,
  output logic [sblc_pkg::LVL_W-1:0] drop_limit_out,
  output logic [sblc_pkg::LVL_W-1:0] pause_level_out,
  output logic [sblc_pkg::LVL_W-1:0] resume_level_out,
  output logic [sblc_pkg::NUM_PORTS-1:0] port_over_limit_out,
  output logic flood_over_limit_out,
  output logic [sblc_pkg::NUM_PORTS-1:0] pause_active_out,
  output logic [sblc_pkg::NUM_PORTS-1:0] pause_frame_out,
  output logic [15:0] pause_time_out
);
  import sblc_pkg::*;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [CFG_W-1:0] cfg;
    logic [LVL_W-1:0] drop_lo;
    logic [LVL_W-1:0] drop_hi;
    logic [LVL_W-1:0] pause_lo;
    logic [LVL_W-1:0] pause_hi;
    logic [LVL_W-1:0] resume_lo;
    logic [LVL_W-1:0] resume_hi;
    logic [LVL_W-1:0] flood_lim;
    logic [31:0] drop_cnt;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [1:0] active;
    logic [LVL_W-1:0] drop_sel;
    logic [LVL_W-1:0] pause_sel;
    logic [LVL_W-1:0] resume_sel;
    logic [NUM_PORTS-1:0] over;
    logic flood_over;
    logic [NUM_PORTS-1:0] pausing;
    logic [NUM_PORTS-1:0] frame;
    logic [15:0] pause_time;
    logic [NUM_PORTS-1:0] yellow;
    logic [NUM_PORTS-1:0] red;
  } sblc_state_s;
  // One struct; the comb block fills a copy, the flop registers it

  sblc_state_s state_reg;
  sblc_state_s state_next;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Maps a byte address to its register index; the low two address bits are dropped
  function automatic logic [13:0] sblc_index(
    input logic [ADDR_W-1:0] addr
  );
    sblc_index = addr[ADDR_W-1:WORD_LSB];
  endfunction

  // Only the six word indices of this bank answer without error
  function automatic logic sblc_mapped(input logic [ADDR_W-1:0] addr);
    logic [13:0] idx;
    idx = sblc_index(addr);
    sblc_mapped = (addr[WORD_LSB-1:0] == 2'b00) &&
      (idx >= IDX_BUFFER_MGR_CONFIG) && (idx <= IDX_HOST_PORT_DROP_COUNTER);
  endfunction

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] sblc_merge(
    input logic [31:0] old_word,
    input logic [31:0] wdata,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old_word;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        res[b*8 +: 8] = wdata[b*8 +: 8];
      end
    end
    sblc_merge = res;
  endfunction

  // Packs a low/high pair into one register word, upper bits zero
  function automatic logic [31:0] sblc_pair(
    input logic [LVL_W-1:0] lo,
    input logic [LVL_W-1:0] hi
  );
    sblc_pair = {16'h0000, lo, hi};
  endfunction

  // ------------------------------------------------------------------
  // Per-port comparisons
  // ------------------------------------------------------------------
  // Levels are 8-bit buffer counts of 128 bytes, zero extended to the usage width
  // Drop and pause compares use >=: reaching the level already counts
  localparam logic [BUF_CNT_W-1:0] ACTIVE_LVL =
    BUF_CNT_W'(ACTIVE_BUFFERS);
  logic [NUM_PORTS-1:0] port_active;
  logic [NUM_PORTS-1:0] at_drop;
  logic [NUM_PORTS-1:0] at_pause;
  logic [NUM_PORTS-1:0] at_resume;

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++)
    begin : g_port
      assign port_active[gp] = port_used_in[gp] >= ACTIVE_LVL;
      assign at_drop[gp] = port_used_in[gp] >=
        BUF_CNT_W'(state_reg.drop_sel);
      assign at_pause[gp] = port_used_in[gp] >=
        BUF_CNT_W'(state_reg.pause_sel);
      assign at_resume[gp] = port_used_in[gp] <=
        BUF_CNT_W'(state_reg.resume_sel);
    end
  endgenerate

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  logic access_first;
  logic access_done;
  logic [13:0] idx;
  logic [31:0] rd_word;
  logic [31:0] wr_word;
  logic [1:0] act_cnt;
  logic use_low;

  always_comb
  begin
    state_next = state_reg;
    idx = sblc_index(paddr_in);
    // Side effects happen on the first access cycle, writes on the last
    // Registered pready marks the second access cycle
    access_first = psel_in && penable_in && !state_reg.pready;
    access_done = psel_in && penable_in && state_reg.pready;
    rd_word = 32'h0000_0000;
    wr_word = 32'h0000_0000;

    act_cnt = 2'b00;
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      act_cnt = act_cnt + {1'b0, port_active[p]};
    end
    // Zero or one active port uses the high set
    use_low = act_cnt >= 2'(LOW_SET_PORTS);
    state_next.active = act_cnt;
    state_next.drop_sel = use_low ? state_reg.drop_lo
      : state_reg.drop_hi;
    state_next.pause_sel = use_low ? state_reg.pause_lo
      : state_reg.pause_hi;
    state_next.resume_sel = use_low ? state_reg.resume_lo
      : state_reg.resume_hi;

    state_next.over = at_drop;
    state_next.flood_over = flood_used_in >=
      BUF_CNT_W'(state_reg.flood_lim);
    state_next.yellow = pkt_yellow_in &
      {NUM_PORTS{state_reg.cfg[CFG_YELLOW]}};
    state_next.red = pkt_red_in &
      {NUM_PORTS{state_reg.cfg[CFG_RED]}};

    // Flow control: pause on entry, pause time one on resume
    // Highest port index sets pause_time when several fire at once
    state_next.frame = '0;
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      if (!state_reg.pausing[p] && at_pause[p])
      begin
        state_next.pausing[p] = 1'b1;
        state_next.frame[p] = 1'b1;
        state_next.pause_time = PAUSE_TIME;
      end
      else if (state_reg.pausing[p] && at_resume[p])
      begin
        state_next.pausing[p] = 1'b0;
        state_next.frame[p] = 1'b1;
        state_next.pause_time = RESUME_PAUSE_TIME;
      end
    end

    // Drop counter, saturating
    // Holding at all ones keeps software from reading a wrapped count
    if (port0_drop_in && state_reg.drop_cnt != CTR_MAX)
    begin
      state_next.drop_cnt = state_reg.drop_cnt + 32'h0000_0001;
    end

    // Read data; reserved bits read as zero
    // Unmapped indices leave the word at zero
    if (idx == IDX_BUFFER_MGR_CONFIG)
    begin
      rd_word = {25'h000_0000, state_reg.cfg};
    end
    else if (idx == IDX_PER_PORT_DROP_LIMITS)
    begin
      rd_word = sblc_pair(state_reg.drop_lo, state_reg.drop_hi);
    end
    else if (idx == IDX_PAUSE_THRESHOLDS)
    begin
      rd_word = sblc_pair(state_reg.pause_lo, state_reg.pause_hi);
    end
    else if (idx == IDX_RESUME_THRESHOLDS)
    begin
      rd_word = sblc_pair(state_reg.resume_lo, state_reg.resume_hi);
    end
    else if (idx == IDX_FLOOD_TRAFFIC_BUFFER_LIMIT)
    begin
      rd_word = {24'h00_0000, state_reg.flood_lim};
    end
    else if (idx == IDX_HOST_PORT_DROP_COUNTER)
    begin
      rd_word = state_reg.drop_cnt;
    end

    // Bus answer: one wait state, error on unmapped addresses
    // Error stands with pready for one cycle only
    state_next.pready = access_first;
    state_next.pslverr = 1'b0;
    if (access_first)
    begin
      state_next.pslverr = !sblc_mapped(paddr_in);
      state_next.prdata = (!pwrite_in && sblc_mapped(paddr_in)) ? rd_word
        : 32'h0000_0000;
      // Clear-on-read, or reload to CTR_TEST_VALUE in counter test mode; a drop in the same cycle is kept, not lost
      if (!pwrite_in && sblc_mapped(paddr_in) &&
          idx == IDX_HOST_PORT_DROP_COUNTER)
      begin
        if (state_reg.cfg[CFG_CTR_TEST])
        begin
          state_next.drop_cnt = CTR_TEST_VALUE +
            {31'h0000_0000, port0_drop_in};
        end
        else
        begin
          state_next.drop_cnt = {31'h0000_0000, port0_drop_in};
        end
      end
    end

    // Writes commit at the edge the master sees pready
    // Reserved bits are dropped by the field slices below
    if (access_done && pwrite_in && sblc_mapped(paddr_in))
    begin
      wr_word = sblc_merge(rd_word, pwdata_in, pstrb_in);
      if (idx == IDX_BUFFER_MGR_CONFIG)
      begin
        state_next.cfg = wr_word[CFG_W-1:0];
      end
      else if (idx == IDX_PER_PORT_DROP_LIMITS)
      begin
        state_next.drop_lo = wr_word[LO_FIELD_LSB +: LVL_W];
        state_next.drop_hi = wr_word[HI_FIELD_LSB +: LVL_W];
      end
      else if (idx == IDX_PAUSE_THRESHOLDS)
      begin
        state_next.pause_lo = wr_word[LO_FIELD_LSB +: LVL_W];
        state_next.pause_hi = wr_word[HI_FIELD_LSB +: LVL_W];
      end
      else if (idx == IDX_RESUME_THRESHOLDS)
      begin
        state_next.resume_lo = wr_word[LO_FIELD_LSB +: LVL_W];
        state_next.resume_hi = wr_word[HI_FIELD_LSB +: LVL_W];
      end
      else if (idx == IDX_FLOOD_TRAFFIC_BUFFER_LIMIT)
      begin
        state_next.flood_lim = wr_word[HI_FIELD_LSB +: LVL_W];
      end
      // The drop counter is read-only; writes to it are ignored
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  // Synchronous reset; selected levels start on the high set
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      state_reg <= '0;
      state_reg.cfg <= CFG_RST;
      state_reg.drop_lo <= DROP_LO_RST;
      state_reg.drop_hi <= DROP_HI_RST;
      state_reg.pause_lo <= PAUSE_LO_RST;
      state_reg.pause_hi <= PAUSE_HI_RST;
      state_reg.resume_lo <= RESUME_LO_RST;
      state_reg.resume_hi <= RESUME_HI_RST;
      state_reg.flood_lim <= FLOOD_RST;
      state_reg.drop_cnt <= DROP_CNT_RST;
      state_reg.drop_sel <= DROP_HI_RST;
      state_reg.pause_sel <= PAUSE_HI_RST;
      state_reg.resume_sel <= RESUME_HI_RST;
      state_reg.pause_time <= PAUSE_TIME_RST;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  // Every output comes straight from the state register
  assign pready_out = state_reg.pready;
  assign prdata_out = state_reg.prdata;
  assign pslverr_out = state_reg.pslverr;
  assign fixed_prio_out = state_reg.cfg[CFG_FIXED_PRIO];
  assign egress_pace_en_out =
    state_reg.cfg[CFG_PACE_HI:CFG_PACE_LO];
  assign yellow_discard_out = state_reg.yellow;
  assign red_drop_out = state_reg.red;
  assign active_ports_out = state_reg.active;
  assign drop_limit_out = state_reg.drop_sel;
  assign pause_level_out = state_reg.pause_sel;
  assign resume_level_out = state_reg.resume_sel;
  assign port_over_limit_out = state_reg.over;
  assign flood_over_limit_out = state_reg.flood_over;
  assign pause_active_out = state_reg.pausing;
  assign pause_frame_out = state_reg.frame;
  assign pause_time_out = state_reg.pause_time;

endmodule

// *** tb/sblc_chk.sv ***
// Port checker for the shared buffer limit control block.
// Assumes it is bound onto sblc_top and sees only that module's ports.
`timescale 1ns/1ps
module sblc_chk
  import sblc_pkg::*;
#(
  parameter int BUF_CNT_W = 9
)
(
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [sblc_pkg::NUM_PORTS-1:0][BUF_CNT_W-1:0] port_used_in,
  input wire logic [sblc_pkg::NUM_PORTS-1:0] pkt_red_in,
  input wire logic [sblc_pkg::NUM_PORTS-1:0] red_drop_out,
  input wire logic fixed_prio_out,
  input wire logic [1:0] active_ports_out,
  input wire logic [sblc_pkg::NUM_PORTS-1:0] pause_active_out,
  input wire logic [sblc_pkg::NUM_PORTS-1:0] pause_frame_out,
  input wire logic [15:0] pause_time_out
);
  logic [1:0] act_cnt;

  always_comb
  begin
    act_cnt = 2'd0;
    for (int i = 0; i < NUM_PORTS; i++)
      act_cnt = act_cnt + 2'(port_used_in[i] >= ACTIVE_BUFFERS);
  end

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rstn_in);

  // ------------------------------------------------------------------
  // Bus phases
  // ------------------------------------------------------------------
  sequence acc_first;
    psel_in && penable_in && !pready_out;
  endsequence
  sequence acc_done;
    psel_in && penable_in && pready_out;
  endsequence

  apb_wait_a: assert property (acc_first |=> acc_done)
    else $error("ready not one cycle after access");
  ready_pulse_a: assert property (pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
  err_ctx_a: assert property (pslverr_out |-> acc_done)
    else $error("error outside a completing access");
  cfg_hold_a: assert property (
    !(psel_in && penable_in && pready_out && pwrite_in)
      |=> $stable(fixed_prio_out))
    else $error("priority mode moved without a write");

  // ------------------------------------------------------------------
  // Threshold and flow behaviour
  // ------------------------------------------------------------------
  red_gate_a: assert property (
    (red_drop_out & ~$past(pkt_red_in)) == '0)
    else $error("red drop without a red packet");
  active_cnt_a: assert property (
    $past(rstn_in) |-> active_ports_out == $past(act_cnt))
    else $error("active port count wrong");
  resume_time_a: assert property (
    (pause_frame_out != '0) && (pause_active_out == '0)
      |-> pause_time_out == RESUME_PAUSE_TIME)
    else $error("resume frame time not one");
  pause_edge_a: assert property (
    $rose(pause_active_out[0]) |-> pause_frame_out[0])
    else $error("pause entered without a frame");
endmodule

// *** tb/switch_buffer_limit_control_tb.sv ***
// Self-checking bench for the shared buffer limit control block.
// Assumes sblc_pkg, sblc_top and sblc_chk are compiled before it.
`timescale 1ns/1ps
module switch_buffer_limit_control_tb;
  import sblc_pkg::*;
  localparam int W = 9;
  logic sys_clk_in = 0;
  logic rstn_in = 0;
  logic psel_in = 0;
  logic penable_in = 0;
  logic pwrite_in = 0;
  logic [ADDR_W-1:0] paddr_in = '0;
  logic [31:0] pwdata_in = '0;
  logic [3:0] pstrb_in = 4'hf;
  logic [NUM_PORTS-1:0][W-1:0] port_used_in = '0;
  logic [W-1:0] flood_used_in = '0;
  logic [NUM_PORTS-1:0] pkt_yellow_in = 3'b110;
  logic [NUM_PORTS-1:0] pkt_red_in = 3'b101;
  logic port0_drop_in = 0;
  logic pready_out, pslverr_out, fixed_prio_out, flood_over_limit_out;
  logic [31:0] prdata_out;
  logic [NUM_PORTS-1:0] egress_pace_en_out, yellow_discard_out, red_drop_out;
  logic [NUM_PORTS-1:0] port_over_limit_out, pause_active_out;
  logic [NUM_PORTS-1:0] pause_frame_out;
  logic [1:0] active_ports_out;
  logic [LVL_W-1:0] drop_limit_out, pause_level_out, resume_level_out;
  logic [15:0] pause_time_out;
  logic [31:0] rd;
  logic er;
  int failures = 0;
  int checks = 0;

  always #12.5 sys_clk_in = ~sys_clk_in;

  sblc_top #(.BUF_CNT_W(W), .PAUSE_TIME(16'h1234)) uut (
    .sys_clk_in, .rstn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .pstrb_in, .pready_out, .prdata_out, .pslverr_out,
    .port_used_in, .flood_used_in, .pkt_yellow_in, .pkt_red_in,
    .port0_drop_in, .fixed_prio_out, .egress_pace_en_out,
    .yellow_discard_out, .red_drop_out, .active_ports_out, .drop_limit_out,
    .pause_level_out, .resume_level_out, .port_over_limit_out,
    .flood_over_limit_out, .pause_active_out, .pause_frame_out,
    .pause_time_out);

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic finish_test();
    if (failures == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge sys_clk_in);
  endtask

  // Holds the request until ready is sampled high, bounded wait
  task automatic apb(input logic wr, input logic [13:0] ix,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= {ix, 2'b00};
    pwdata_in <= wd;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    do
    begin
      @(posedge sys_clk_in);
      n++;
    end
    while (pready_out !== 1'b1 && n < 9);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    if (n >= 9)
    begin
      failures++;
      $display("BAD %0t bus timeout", $time);
      finish_test();
    end
  endtask

  task automatic rchk(input logic [13:0] ix, input logic [31:0] ex);
    apb(1'b0, ix, 32'h0000_0000);
    cmp(rd, ex);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    rchk(IDX_BUFFER_MGR_CONFIG, 32'h0000_0000);
    rchk(IDX_PER_PORT_DROP_LIMITS, 32'h0000_4964);
    rchk(IDX_PAUSE_THRESHOLDS, 32'h0000_213c);
    rchk(IDX_RESUME_THRESHOLDS, 32'h0000_0307);
    rchk(IDX_FLOOD_TRAFFIC_BUFFER_LIMIT, 32'h0000_0031);
    rchk(IDX_HOST_PORT_DROP_COUNTER, 32'h0000_0000);
    rchk(14'h1c06, 32'h0000_0000);
    cmp({31'b0, er}, 32'h0000_0001);
  endtask

  task automatic cfg_case(input logic [31:0] wd, input logic [9:0] ex);
    apb(1'b1, IDX_BUFFER_MGR_CONFIG, wd);
    step(2);
    cmp({22'b0, fixed_prio_out, egress_pace_en_out, yellow_discard_out,
         red_drop_out}, {22'b0, ex});
  endtask

  task automatic flow_step(input logic [W-1:0] u, input logic [15:0] tm,
                           input logic act);
    int n;
    n = 0;
    port_used_in[0] <= u;
    do
    begin
      @(posedge sys_clk_in);
      n++;
    end
    while (pause_frame_out[0] !== 1'b1 && n < 9);
    if (n >= 9)
    begin
      failures++;
      $display("BAD %0t no pause frame", $time);
      finish_test();
    end
    cmp({16'b0, pause_time_out}, {16'b0, tm});
    step(1);
    cmp({30'b0, pause_active_out[0], pause_frame_out[0]}, {30'b0, act, 1'b0});
  endtask

  task automatic t_levels();
    logic [24:0] lv;
    apb(1'b1, IDX_PER_PORT_DROP_LIMITS, 32'hffff_5a20);
    rchk(IDX_PER_PORT_DROP_LIMITS, 32'h0000_5a20);
    for (int n = 0; n < 4; n++)
    begin
      for (int i = 0; i < NUM_PORTS; i++)
        port_used_in[i] <= (i < n) ? 9'd36 : 9'd35;
      step(3);
      lv = (n < 2) ? {8'h20, 8'h3c, 8'h07, 1'b1} : {8'h5a, 8'h21, 8'h03, 1'b0};
      cmp({5'b0, active_ports_out, drop_limit_out, pause_level_out,
           resume_level_out, port_over_limit_out[0]},
          {5'b0, 2'(n), lv});
    end
    for (int v = 48; v < 50; v++)
    begin
      flood_used_in <= 9'(v);
      step(2);
      cmp({31'b0, flood_over_limit_out}, {31'b0, v == 49});
    end
  endtask

  task automatic t_count();
    repeat (5)
    begin
      @(posedge sys_clk_in);
      port0_drop_in <= 1'b1;
      @(posedge sys_clk_in);
      port0_drop_in <= 1'b0;
    end
    apb(1'b1, IDX_HOST_PORT_DROP_COUNTER, 32'h0000_0009);
    rchk(IDX_HOST_PORT_DROP_COUNTER, 32'h0000_0005);
    rchk(IDX_HOST_PORT_DROP_COUNTER, 32'h0000_0000);
    apb(1'b1, IDX_BUFFER_MGR_CONFIG, 32'h0000_0040);
    rchk(IDX_HOST_PORT_DROP_COUNTER, 32'h0000_0000);
    rchk(IDX_HOST_PORT_DROP_COUNTER, 32'h7fff_fffc);
  endtask

  initial
  begin
    repeat (2) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    t_reset();
    cfg_case(32'hffff_ffa3, 10'b1_000_110_101);
    rchk(IDX_BUFFER_MGR_CONFIG, 32'h0000_0023);
    cfg_case(32'h0000_0018, 10'b0_110_000_000);
    flow_step(9'h03c, 16'h1234, 1'b1);
    flow_step(9'h007, 16'h0001, 1'b0);
    t_levels();
    t_count();
    finish_test();
  end
endmodule

bind sblc_top sblc_chk #(.BUF_CNT_W(BUF_CNT_W)) chk_i (
  .sys_clk_in, .rstn_in, .psel_in, .penable_in, .pwrite_in, .pready_out,
  .pslverr_out, .port_used_in, .pkt_red_in, .red_drop_out, .fixed_prio_out,
  .active_ports_out, .pause_active_out, .pause_frame_out, .pause_time_out);
